// [rtl/cpc_pkg.sv]
// Constants shared by the codec port control block
package cpc_pkg;
  // Register byte offsets
  localparam logic [7:0] CPC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] CPC_OFS_STATUS = 8'h04;
  // Control field positions
  localparam int CPC_AUD_DIV_LSB = 0;
  localparam int CPC_TEL_DIV_LSB = 8;
  localparam int CPC_DIV_W = 7;
  localparam int CPC_BIT_ENABLE = 16;
  localparam int CPC_BIT_RSVD17 = 17;
  localparam int CPC_BIT_SAMPLE_SEL = 18;
  localparam int CPC_BIT_TEL_TX_MASK = 19;
  localparam int CPC_BIT_TEL_RX_MASK = 20;
  localparam int CPC_BIT_AUD_TX_MASK = 21;
  localparam int CPC_BIT_AUD_RX_MASK = 22;
  localparam int CPC_BIT_LOOPBACK = 23;
  // Writable bits of the control register, everything else reads zero
  localparam logic [31:0] CPC_CONTROL_WMASK = 32'h00fd7f7f;
  localparam logic [31:0] CPC_CONTROL_RESET = 32'h00000000;
  // Divisor limits
  localparam logic [6:0] CPC_AUD_DIV_MIN = 7'h06;
  localparam logic [6:0] CPC_TEL_DIV_MIN = 7'h10;
  // Serial clock periods per divisor step
  localparam int CPC_PRESCALE = 32;
  localparam logic [4:0] CPC_PRESCALE_LAST = 5'(CPC_PRESCALE - 1);
  // Status field positions
  localparam int CPC_ST_RAW_LSB = 0;
  localparam int CPC_ST_MASKED_LSB = 4;
  localparam int CPC_ST_IRQ = 8;
  localparam int CPC_ST_PINS = 9;
  localparam int CPC_ST_PPC = 10;
  localparam int CPC_ST_AUD_ARMED = 11;
  localparam int CPC_ST_TEL_ARMED = 12;
  localparam int CPC_ST_AUD_CNT_LSB = 16;
  localparam int CPC_ST_TEL_CNT_LSB = 24;
  // AHB encodings
  localparam logic [1:0] CPC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] CPC_HTRANS_SEQ = 2'h3;
  localparam logic CPC_HRESP_OKAY = 1'h0;
endpackage

// [rtl/cpc_rate_counter.sv]
// Sample-rate counter: counts divided serial clock ticks and flags each time-out
`timescale 1ns/100ps
`default_nettype none
module cpc_rate_counter import cpc_pkg::*; (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic run_in,
  input wire logic tick_in,
  input wire logic [6:0] divisor_in,
  input wire logic [6:0] div_min_in,
  output logic [6:0] count_out,
  output logic timeout_out
);
  logic [6:0] div_eff;
  logic [6:0] cnt_q;
  logic timeout_q;

  // Out-of-range divisors are held at the floor
  assign div_eff = (divisor_in < div_min_in) ? div_min_in : divisor_in;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= 7'h00;
    end else if (!run_in) begin
      cnt_q <= 7'h00;
    end else if (tick_in) begin
      if (cnt_q == 7'h00) begin
        cnt_q <= div_eff - 7'h01;
      end else begin
        cnt_q <= cnt_q - 7'h01;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= run_in && tick_in && (cnt_q == 7'h00);
    end
  end

  assign count_out = cnt_q;
  assign timeout_out = timeout_q;

  property p_timeout_on_reload;
    @(posedge mclk_in) disable iff (!nrst_in)
      timeout_q |-> $past(cnt_q == 7'h00) && $past(tick_in) && (cnt_q == $past(div_eff) - 7'h01);
  endproperty
  a_timeout_on_reload: assert property (p_timeout_on_reload) else $error("Time-out without reload");

  property p_div_floor;
    @(posedge mclk_in) disable iff (!nrst_in)
      run_in && tick_in && cnt_q == 7'h00 |=> cnt_q >= div_min_in - 7'h01;
  endproperty
  a_div_floor: assert property (p_div_floor) else $error("Divisor reloaded below floor");
endmodule
`default_nettype wire

// [rtl/cpc_rx_capture.sv]
// Receive sample capture decision for one channel
`timescale 1ns/100ps
`default_nettype none
module cpc_rx_capture (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic enable_in,
  input wire logic mode_in,
  input wire logic frame_in,
  input wire logic valid_in,
  input wire logic timeout_in,
  output logic armed_out,
  output logic store_out
);
  logic armed_q;
  logic pend_q;
  logic store_q;
  logic take;

  // Mode 0 follows data-valid; mode 1 takes the first valid then counter time-outs
  assign take = enable_in && frame_in && (mode_in ? (armed_q ? pend_q : valid_in) : valid_in);

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      armed_q <= 1'b0;
    end else if (!enable_in || !mode_in) begin
      armed_q <= 1'b0;
    end else if (take) begin
      armed_q <= 1'b1;
    end
  end

  // A time-out marks the next frame as holding a fresh sample; set wins over clear
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_q <= 1'b0;
    end else if (!enable_in || !armed_q) begin
      pend_q <= 1'b0;
    end else if (timeout_in) begin
      pend_q <= 1'b1;
    end else if (frame_in) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      store_q <= 1'b0;
    end else begin
      store_q <= take;
    end
  end

  assign armed_out = armed_q;
  assign store_out = store_q;

  property p_mode0_store;
    @(posedge mclk_in) disable iff (!nrst_in)
      enable_in && !mode_in && frame_in && valid_in |=> store_q;
  endproperty
  a_mode0_store: assert property (p_mode0_store) else $error("Valid sample not stored");

  property p_mode1_first_valid;
    @(posedge mclk_in) disable iff (!nrst_in)
      enable_in && mode_in && !armed_q && frame_in && valid_in |=> store_q && armed_q;
  endproperty
  a_mode1_first_valid: assert property (p_mode1_first_valid) else $error("First valid sample not taken");

  property p_mode1_ignore_valid;
    @(posedge mclk_in) disable iff (!nrst_in)
      enable_in && mode_in && armed_q && !pend_q && frame_in |=> !store_q;
  endproperty
  a_mode1_ignore_valid: assert property (p_mode1_ignore_valid) else $error("Sample stored without time-out");
endmodule
`default_nettype wire

// [rtl/cpc_port_control.sv]
// Codec port control register, rate counters, pin handover, capture and interrupt
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cpc_port_control import cpc_pkg::*; (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic telecom_tx_service_req_in,
  input wire logic telecom_rx_service_req_in,
  input wire logic audio_tx_service_req_in,
  input wire logic audio_rx_service_req_in,
  input wire logic [3:0] fixed_irq_in,
  input wire logic port_pin_select_in,
  input wire logic serial_clock_tick_in,
  input wire logic frame_done_in,
  input wire logic audio_rx_valid_in,
  input wire logic telecom_rx_valid_in,
  input wire logic shifter_msb_in,
  input wire logic shifter_sync_in,
  input wire logic shifter_clock_in,
  input wire logic link_serial_in_in,
  output logic shifter_lsb_out,
  output logic link_serial_out_out,
  output logic link_serial_out_oe_out,
  output logic link_frame_sync_out,
  output logic link_frame_sync_oe_out,
  output logic link_serial_clock_out,
  output logic link_serial_clock_oe_out,
  output logic port_active_out,
  output logic pins_to_port_out,
  output logic ppc_owns_pins_out,
  output logic audio_tx_slot_out,
  output logic telecom_tx_slot_out,
  output logic audio_store_out,
  output logic telecom_store_out,
  output logic irq_out
);
  logic [31:0] ctrl_q;
  logic dph_wr_q;
  logic dph_rd_q;
  logic [7:0] dph_addr_q;
  logic [31:0] rdata_q;
  logic [4:0] pre_q;
  logic div_tick;
  logic port_enable;
  logic sample_sel;
  logic loopback_sel;
  logic pins_own;
  logic [3:0] svc_raw;
  logic [3:0] svc_mask;
  logic [3:0] svc_masked;
  logic irq_d;
  logic irq_q;
  logic [6:0] aud_cnt;
  logic [6:0] tel_cnt;
  logic aud_timeout;
  logic tel_timeout;
  logic aud_armed;
  logic tel_armed;
  logic addr_valid;
  logic [31:0] status_word;
  logic [31:0] rdata_d;
  logic lsb_q;
  logic sdo_q;
  logic sync_q;
  logic sck_q;
  logic pins_q;
  logic ppc_q;

  assign port_enable = ctrl_q[CPC_BIT_ENABLE];
  assign sample_sel = ctrl_q[CPC_BIT_SAMPLE_SEL];
  assign loopback_sel = ctrl_q[CPC_BIT_LOOPBACK];

  // AHB-Lite slave: zero wait states, always OKAY
  assign addr_valid = hsel_in && hready_in && (htrans_in == CPC_HTRANS_NONSEQ || htrans_in == CPC_HTRANS_SEQ);
  assign hreadyout_out = 1'b1;
  assign hresp_out = CPC_HRESP_OKAY;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dph_wr_q <= 1'b0;
      dph_rd_q <= 1'b0;
      dph_addr_q <= 8'h00;
    end else begin
      dph_wr_q <= addr_valid && hwrite_in;
      dph_rd_q <= addr_valid && !hwrite_in;
      if (addr_valid) begin
        dph_addr_q <= haddr_in[7:0];
      end
    end
  end

  // Control register; reserved bits never store
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q <= CPC_CONTROL_RESET;
    end else if (dph_wr_q && dph_addr_q == CPC_OFS_CONTROL) begin
      ctrl_q <= hwdata_in & CPC_CONTROL_WMASK;
    end
  end

  // Status word shows the block's own state
  always_comb begin
    status_word = 32'h00000000;
    status_word[CPC_ST_RAW_LSB +: 4] = svc_raw;
    status_word[CPC_ST_MASKED_LSB +: 4] = svc_masked;
    status_word[CPC_ST_IRQ] = irq_q;
    status_word[CPC_ST_PINS] = pins_q;
    status_word[CPC_ST_PPC] = ppc_q;
    status_word[CPC_ST_AUD_ARMED] = aud_armed;
    status_word[CPC_ST_TEL_ARMED] = tel_armed;
    status_word[CPC_ST_AUD_CNT_LSB +: CPC_DIV_W] = aud_cnt;
    status_word[CPC_ST_TEL_CNT_LSB +: CPC_DIV_W] = tel_cnt;
  end

  // Read data is sampled in the address phase so the data phase sees a flop
  always_comb begin
    rdata_d = 32'h00000000;
    if (addr_valid && !hwrite_in) begin
      if (haddr_in[7:0] == CPC_OFS_CONTROL) begin
        rdata_d = ctrl_q & CPC_CONTROL_WMASK;
      end else if (haddr_in[7:0] == CPC_OFS_STATUS) begin
        rdata_d = status_word;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata_out = rdata_q;

  // Serial clock periods divided by 32
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_q <= 5'h00;
    end else if (!port_enable) begin
      pre_q <= 5'h00;
    end else if (serial_clock_tick_in) begin
      pre_q <= pre_q + 5'h01;
    end
  end

  assign div_tick = port_enable && serial_clock_tick_in && (pre_q == CPC_PRESCALE_LAST);

  cpc_rate_counter u_aud_rate (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .run_in(port_enable),
    .tick_in(div_tick),
    .divisor_in(ctrl_q[CPC_AUD_DIV_LSB +: CPC_DIV_W]),
    .div_min_in(CPC_AUD_DIV_MIN),
    .count_out(aud_cnt),
    .timeout_out(aud_timeout)
  );

  cpc_rate_counter u_tel_rate (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .run_in(port_enable),
    .tick_in(div_tick),
    .divisor_in(ctrl_q[CPC_TEL_DIV_LSB +: CPC_DIV_W]),
    .div_min_in(CPC_TEL_DIV_MIN),
    .count_out(tel_cnt),
    .timeout_out(tel_timeout)
  );

  assign audio_tx_slot_out = aud_timeout;
  assign telecom_tx_slot_out = tel_timeout;

  cpc_rx_capture u_aud_capture (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .enable_in(port_enable),
    .mode_in(sample_sel),
    .frame_in(frame_done_in),
    .valid_in(audio_rx_valid_in),
    .timeout_in(aud_timeout),
    .armed_out(aud_armed),
    .store_out(audio_store_out)
  );

  cpc_rx_capture u_tel_capture (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .enable_in(port_enable),
    .mode_in(sample_sel),
    .frame_in(frame_done_in),
    .valid_in(telecom_rx_valid_in),
    .timeout_in(tel_timeout),
    .armed_out(tel_armed),
    .store_out(telecom_store_out)
  );

  // Service requests in order: telecom tx, telecom rx, audio tx, audio rx
  assign svc_raw = {audio_rx_service_req_in, audio_tx_service_req_in,
                    telecom_rx_service_req_in, telecom_tx_service_req_in};
  assign svc_mask = {ctrl_q[CPC_BIT_AUD_RX_MASK], ctrl_q[CPC_BIT_AUD_TX_MASK],
                     ctrl_q[CPC_BIT_TEL_RX_MASK], ctrl_q[CPC_BIT_TEL_TX_MASK]};

  for (genvar gi = 0; gi < 4; gi++) begin : g_mask
    assign svc_masked[gi] = svc_raw[gi] && svc_mask[gi];
  end

  assign irq_d = (|svc_masked) || (|fixed_irq_in);

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq_out = irq_q;

  // Pins belong to the port only when enabled, selected and not looping back
  assign pins_own = port_enable && port_pin_select_in && !loopback_sel;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pins_q <= 1'b0;
      ppc_q <= 1'b0;
    end else begin
      pins_q <= pins_own;
      ppc_q <= port_enable && loopback_sel;
    end
  end

  assign pins_to_port_out = pins_q;
  assign ppc_owns_pins_out = ppc_q;
  assign port_active_out = port_enable;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sdo_q <= 1'b0;
      sync_q <= 1'b0;
      sck_q <= 1'b0;
    end else begin
      sdo_q <= pins_own && shifter_msb_in;
      sync_q <= pins_own && shifter_sync_in;
      sck_q <= pins_own && shifter_clock_in;
    end
  end

  // Pin enables share the ownership flop, so they move with the values
  assign link_serial_out_out = sdo_q;
  assign link_serial_out_oe_out = pins_q;
  assign link_frame_sync_out = sync_q;
  assign link_frame_sync_oe_out = pins_q;
  assign link_serial_clock_out = sck_q;
  assign link_serial_clock_oe_out = pins_q;

  // Shifter input: internal loop, the pin, or idle low
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lsb_q <= 1'b0;
    end else if (port_enable && loopback_sel) begin
      lsb_q <= shifter_msb_in;
    end else if (pins_own) begin
      lsb_q <= link_serial_in_in;
    end else begin
      lsb_q <= 1'b0;
    end
  end

  assign shifter_lsb_out = lsb_q;

  property p_disabled_quiet;
    @(posedge mclk_in) disable iff (!nrst_in)
      !port_enable |-> !port_active_out ##1 !pins_to_port_out && !link_serial_out_oe_out && !link_frame_sync_oe_out
        && !link_serial_clock_oe_out;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("Disabled port holds pins");

  property p_pins_need_select;
    @(posedge mclk_in) disable iff (!nrst_in)
      pins_to_port_out |-> $past(port_pin_select_in) && $past(port_enable) && !$past(loopback_sel);
  endproperty
  a_pins_need_select: assert property (p_pins_need_select) else $error("Pins taken without select");

  property p_reserved_read_zero;
    @(posedge mclk_in) disable iff (!nrst_in)
      dph_rd_q && dph_addr_q == CPC_OFS_CONTROL |-> (hrdata_out & ~CPC_CONTROL_WMASK) == 32'h00000000;
  endproperty
  a_reserved_read_zero: assert property (p_reserved_read_zero) else $error("Reserved bits read nonzero");

  property p_write_stores;
    @(posedge mclk_in) disable iff (!nrst_in)
      dph_wr_q && dph_addr_q == CPC_OFS_CONTROL |=> ctrl_q == ($past(hwdata_in) & CPC_CONTROL_WMASK);
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("Control write not stored");

  property p_reset_disables;
    @(posedge mclk_in) $rose(nrst_in) |-> !port_enable && !irq_out;
  endproperty
  a_reset_disables: assert property (p_reset_disables) else $error("Enable set after reset");

  property p_irq_or;
    @(posedge mclk_in) disable iff (!nrst_in)
      ##1 irq_out == ($past(|(svc_raw & svc_mask)) || $past(|fixed_irq_in));
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("Interrupt is not OR of masked sources");

  property p_tel_tx_gate;
    @(posedge mclk_in) disable iff (!nrst_in)
      telecom_tx_service_req_in && ctrl_q[CPC_BIT_TEL_TX_MASK] |=> irq_out;
  endproperty
  a_tel_tx_gate: assert property (p_tel_tx_gate) else $error("Telecom tx request not forwarded");

  property p_tel_rx_gate;
    @(posedge mclk_in) disable iff (!nrst_in)
      telecom_rx_service_req_in && ctrl_q[CPC_BIT_TEL_RX_MASK] |=> irq_out;
  endproperty
  a_tel_rx_gate: assert property (p_tel_rx_gate) else $error("Telecom rx request not forwarded");

  property p_aud_tx_gate;
    @(posedge mclk_in) disable iff (!nrst_in)
      audio_tx_service_req_in && ctrl_q[CPC_BIT_AUD_TX_MASK] |=> irq_out;
  endproperty
  a_aud_tx_gate: assert property (p_aud_tx_gate) else $error("Audio tx request not forwarded");

  property p_aud_rx_masked;
    @(posedge mclk_in) disable iff (!nrst_in)
      !ctrl_q[CPC_BIT_AUD_RX_MASK] && (svc_raw[2:0] & svc_mask[2:0]) == 3'h0 && fixed_irq_in == 4'h0 |=> !irq_out;
  endproperty
  a_aud_rx_masked: assert property (p_aud_rx_masked) else $error("Masked audio rx request raised interrupt");

  property p_loopback_path;
    @(posedge mclk_in) disable iff (!nrst_in)
      port_enable && loopback_sel |=> shifter_lsb_out == $past(shifter_msb_in) && !link_serial_out_oe_out;
  endproperty
  a_loopback_path: assert property (p_loopback_path) else $error("Loopback path broken");
endmodule
`default_nettype wire

// [verif/cpc_codec_model.sv]
// Codec-side model: serial clock ticks, received frame ends and data-valid bits
`timescale 1ns/100ps
`default_nettype none
module cpc_codec_model (
  input wire logic mclk_in,
  input wire logic nrst_in,
  output logic tick_out,
  output logic frame_done_out,
  output logic audio_valid_out,
  output logic telecom_valid_out,
  output logic serial_in_out
);
  logic [7:0] phase_q;
  // One serial clock period every second host clock, so rates are exact tick counts
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_q <= 8'h00;
    end else begin
      phase_q <= phase_q + 8'h01;
    end
  end
  assign tick_out = phase_q[0];
  assign serial_in_out = phase_q[1];
  initial begin
    frame_done_out = 1'b0;
    audio_valid_out = 1'b1;
    telecom_valid_out = 1'b1;
  end
  // Valid bits mean something only at frame end; between frames they show the inverse
  task automatic send_frame(input logic av, input logic tv);
    @(posedge mclk_in);
    frame_done_out <= 1'b1;
    audio_valid_out <= av;
    telecom_valid_out <= tv;
    @(posedge mclk_in);
    frame_done_out <= 1'b0;
    audio_valid_out <= !av;
    telecom_valid_out <= !tv;
  endtask
endmodule
`default_nettype wire

// [verif/codec_port_control_test.sv]
// Self-checking testbench for the codec port control block
`timescale 1ns/100ps
`default_nettype none
module codec_port_control_test;
  import cpc_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] sreq = 4'h0;
  logic [3:0] fixed_irq = 4'h0;
  logic sel = 1'b0;
  logic sh_msb = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hready, tick, fdone, aval, tval, ser_in, lsb, sout, sout_oe, sync_oe, clk_oe;
  wire logic active, pins, peripheral_pin_controller, aslot, tslot, astore, tstore, irq, hresp, syncv, sckv;
  wire logic [8:0] pinv = {syncv, sckv, pins, sout_oe, sync_oe, clk_oe, sout, peripheral_pin_controller, active};
  logic ser_prev = 1'b0;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int ticks = 0;
  int a_last = 0, a_prev = 0, a_n = 0, t_last = 0, t_prev = 0, t_n = 0, as_n = 0, ts_n = 0;

  always #10 mclk = ~mclk;

  cpc_codec_model codec_u (.mclk_in(mclk), .nrst_in(nrst), .tick_out(tick), .frame_done_out(fdone),
    .audio_valid_out(aval), .telecom_valid_out(tval), .serial_in_out(ser_in));

  cpc_port_control dut_u (.mclk_in(mclk), .nrst_in(nrst), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hready), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .telecom_tx_service_req_in(sreq[0]), .telecom_rx_service_req_in(sreq[1]),
    .audio_tx_service_req_in(sreq[2]), .audio_rx_service_req_in(sreq[3]), .fixed_irq_in(fixed_irq),
    .port_pin_select_in(sel), .serial_clock_tick_in(tick), .frame_done_in(fdone),
    .audio_rx_valid_in(aval), .telecom_rx_valid_in(tval), .shifter_msb_in(sh_msb),
    .shifter_sync_in(!sh_msb), .shifter_clock_in(sh_msb), .link_serial_in_in(ser_in),
    .shifter_lsb_out(lsb), .link_serial_out_out(sout), .link_serial_out_oe_out(sout_oe),
    .link_frame_sync_out(syncv), .link_frame_sync_oe_out(sync_oe), .link_serial_clock_out(sckv),
    .link_serial_clock_oe_out(clk_oe), .port_active_out(active), .pins_to_port_out(pins),
    .ppc_owns_pins_out(peripheral_pin_controller), .audio_tx_slot_out(aslot), .telecom_tx_slot_out(tslot),
    .audio_store_out(astore), .telecom_store_out(tstore), .irq_out(irq));

  // Tick positions of slot pulses and counts of store pulses
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    ser_prev <= ser_in;
    if (tick === 1'b1) ticks <= ticks + 1;
    if (aslot === 1'b1) begin
      a_prev <= a_last;
      a_last <= ticks;
      a_n <= a_n + 1;
    end
    if (tslot === 1'b1) begin
      t_prev <= t_last;
      t_last <= ticks;
      t_n <= t_n + 1;
    end
    if (astore === 1'b1) as_n <= as_n + 1;
    if (tstore === 1'b1) ts_n <= ts_n + 1;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    htrans <= CPC_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] d);
    logic [31:0] q;
    ahb_xfer(1'b1, CPC_OFS_CONTROL, d, q);
    wait_cyc(3);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    ahb_xfer(1'b0, CPC_OFS_CONTROL, 32'h0, q);
    chk("control at reset", 32'h00000000, q);
    chk("port active at reset", 32'h0, {31'h0, active});
    chk("hresp okay", {31'h0, CPC_HRESP_OKAY}, {31'h0, hresp});
    wr(32'hfffdffff);
    ahb_xfer(1'b0, CPC_OFS_CONTROL, 32'h0, q);
    chk("control readback", 32'h00fd7f7f, q);
    ahb_xfer(1'b0, 8'h10, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    wr(32'h0);
    $display("test regs done");
  endtask

  task automatic t_irq();
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      sreq <= 4'h1 << i;
      wr(32'h1 << (19 + i));
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(32'h00780000 & ~(32'h1 << (19 + i)));
      chk("irq masked", 32'h0, {31'h0, irq});
    end
    sreq <= 4'h0;
    fixed_irq <= 4'h4;
    wait_cyc(3);
    chk("irq fixed source", 32'h1, {31'h0, irq});
    fixed_irq <= 4'h0;
    sreq <= 4'h5;
    wait_cyc(3);
    ahb_xfer(1'b0, CPC_OFS_STATUS, 32'h0, q);
    chk("status word", 32'h00000155, q);
    sreq <= 4'h0;
    wr(32'h0);
    $display("test irq done");
  endtask

  task automatic t_pins();
    sh_msb <= 1'b1;
    sel <= 1'b1;
    wait_cyc(3);
    chk("pins disabled", 32'h0, {23'h0, pinv});
    sel <= 1'b0;
    wr(32'h00010000);
    chk("pins not selected", 32'h1, {23'h0, pinv});
    sel <= 1'b1;
    wait_cyc(3);
    chk("pins driven", 32'hfd, {23'h0, pinv});
    chk("pin to shifter", {31'h0, ser_prev}, {31'h0, lsb});
    wr(32'h00810000);
    chk("loopback pins", 32'h3, {23'h0, pinv});
    chk("loopback high", 32'h1, {31'h0, lsb});
    sh_msb <= 1'b0;
    wait_cyc(3);
    chk("loopback low", 32'h0, {31'h0, lsb});
    wr(32'h0);
    $display("test pins done");
  endtask

  task automatic t_rate();
    int a0, t0;
    wr(32'h00011006);
    a0 = a_n;
    t0 = t_n;
    for (int k = 0; k < 4000 && (a_n < a0 + 2 || t_n < t0 + 2); k++) @(posedge mclk);
    chk("audio slot ticks", 32'd192, 32'(a_last - a_prev));
    chk("telecom slot ticks", 32'd512, 32'(t_last - t_prev));
    $display("test rate done");
  endtask

  task automatic t_sample();
    int s0, t0, n0;
    s0 = as_n;
    t0 = ts_n;
    codec_u.send_frame(1'b1, 1'b1);
    codec_u.send_frame(1'b0, 1'b0);
    codec_u.send_frame(1'b1, 1'b0);
    wait_cyc(3);
    chk("audio stores mode 0", 32'd2, 32'(as_n - s0));
    chk("telecom stores mode 0", 32'd1, 32'(ts_n - t0));
    wr(32'h0);
    wr(32'h00051006);
    s0 = as_n;
    codec_u.send_frame(1'b1, 1'b1);
    codec_u.send_frame(1'b1, 1'b1);
    wait_cyc(3);
    chk("audio first valid only", 32'd1, 32'(as_n - s0));
    n0 = a_n;
    for (int k = 0; k < 1000 && a_n == n0; k++) @(posedge mclk);
    codec_u.send_frame(1'b0, 1'b0);
    wait_cyc(3);
    chk("audio store on time-out", 32'd2, 32'(as_n - s0));
    $display("test sample done");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_irq();
    t_pins();
    t_rate();
    t_sample();
    final_report();
  end
endmodule
`default_nettype wire
